// *** aop_consts.svh ***
// Constants for the oversampling, limit and power block
`ifndef AOP_CONSTS_SVH
`define AOP_CONSTS_SVH
`define AOP_HIST_DEPTH      8
`define AOP_NATIVE_W        16
`define AOP_BOOST_BITS      2
`define AOP_OSR_W           3
`define AOP_OSR_OFF         3'h0
`define AOP_OSR_2           3'h1
`define AOP_OSR_4           3'h2
`define AOP_OSR_8           3'h3
`define AOP_SEQ_LAT         2
`define AOP_CONV_NS         240
`define AOP_CLK_NS          20
`define AOP_CONV_CYC        ((`AOP_CONV_NS + `AOP_CLK_NS - 1) / `AOP_CLK_NS)
`define AOP_NORM_GAP_NS     300
`define AOP_NORM_GAP_CYC    ((`AOP_NORM_GAP_NS + `AOP_CLK_NS - 1) / `AOP_CLK_NS)
`define AOP_FIFO_DEPTH      16
`endif

// *** aop_fifo.sv ***
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module aop_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_no_over: assert property (@(posedge core_clk) disable iff (!resetn)
		count <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule : aop_fifo

// *** aop_filter.sv ***
`timescale 1ns/1ps
`include "aop_consts.svh"
module aop_filter
	import aop_pkg::*;
#(
	parameter int NW    = `AOP_NATIVE_W,
	parameter int OW    = `AOP_NATIVE_W + `AOP_BOOST_BITS,
	parameter int DEPTH = `AOP_HIST_DEPTH
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          resetn,
	// Serial framing from the host
	input  wire logic          cs_n,
	input  wire logic          sclk,
	// Converter results, ready after each conversion
	input  wire logic [NW-1:0] conv_a,
	input  wire logic [NW-1:0] conv_b,
	// Configuration
	input  wire logic [2:0]    oversample_ratio_field,
	input  wire logic          averaging_mode_select,
	input  wire logic          resolution_boost_enable,
	input  wire logic          channel_sequencer_enable,
	input  wire logic          reference_source_select,
	input  wire logic          serial_output_lane_select,
	input  wire logic          limit_flag_enable,
	input  wire logic          power_down_select,
	input  wire logic          soft_reset,
	input  wire logic          hard_reset,
	input  wire logic [NW-1:0] upper_limit,
	input  wire logic [NW-1:0] lower_limit,
	// Converter control
	output logic               sample_hold,
	output logic               mux_select,
	output logic               analog_power_down,
	// Results stream
	output logic               result_valid,
	input  wire logic          result_ready,
	output logic [2*OW-1:0]    result_data,
	output logic               result_boosted,
	// Status
	output logic [3:0]         limit_status,
	output logic               flag_out,
	output logic               flag_oe_n,
	output logic               sclk_edge
);
	logic [1:0]       cs_sync;
	logic [1:0]       sclk_sync;
	logic             cs_prev;
	logic             sclk_prev;
	logic             cs_fall;
	aop_state_e       state;
	logic [7:0]       timer;
	logic [3:0]       samples_left;
	logic [1:0]       seq_wait;
	logic             ref_prev;
	logic             need_fill;
	logic [NW-1:0]    hist_a [DEPTH];
	logic [NW-1:0]    hist_b [DEPTH];
	logic [NW+3:0]    norm_sum_a;
	logic [NW+3:0]    norm_sum_b;
	logic [NW+3:0]    sum_a;
	logic [NW+3:0]    sum_b;
	logic [1:0]       shift;
	logic             os_valid;
	logic             rolling;
	logic             boost;
	logic [OW-1:0]    avg_a;
	logic [OW-1:0]    avg_b;
	logic             fifo_ready;
	logic             push;
	logic             sw_reset;

	assign cs_fall  = cs_prev && !cs_sync[1];
	assign sw_reset = soft_reset || hard_reset;
	assign os_valid = (oversample_ratio_field == `AOP_OSR_2) ||
		(oversample_ratio_field == `AOP_OSR_4) ||
		(oversample_ratio_field == `AOP_OSR_8);
	assign rolling  = os_valid && averaging_mode_select;
	assign boost    = resolution_boost_enable && os_valid;
	assign shift    = os_valid ? oversample_ratio_field[1:0] : 2'h0;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cs_sync   <= 2'h3;
			sclk_sync <= 2'h0;
			cs_prev   <= 1'b1;
			sclk_prev <= 1'b0;
			sclk_edge <= 1'b0;
		end else begin
			cs_sync   <= {cs_sync[0], cs_n};
			sclk_sync <= {sclk_sync[0], sclk};
			cs_prev   <= cs_sync[1];
			sclk_prev <= sclk_sync[1];
			// Interface stays alive while powered down
			sclk_edge <= !cs_sync[1] && sclk_sync[1] && !sclk_prev;
		end
	end

	// ****************************************
	// Conversion sequencing
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state        <= AOP_IDLE;
			timer        <= 8'h0;
			samples_left <= 4'h0;
			seq_wait     <= 2'h0;
			sample_hold  <= 1'b0;
			mux_select   <= 1'b0;
		end else if (sw_reset) begin
			state       <= AOP_IDLE;
			sample_hold <= 1'b0;
			mux_select  <= 1'b0;
		end else begin
			case (state)
			AOP_IDLE: begin
				// Only a chip-select fall may begin work
				if (cs_fall && !power_down_select) begin
					samples_left <= (os_valid && !rolling) ?
						(4'h1 << shift) : 4'h1;
					if (channel_sequencer_enable && os_valid) begin
						seq_wait <= 2'(`AOP_SEQ_LAT);
						state    <= AOP_WAIT;
					end else begin
						sample_hold <= 1'b1;
						timer       <= 8'(`AOP_CONV_CYC);
						state       <= AOP_CONV;
					end
				end
			end
			AOP_WAIT: begin
				seq_wait <= seq_wait - 2'h1;
				if (seq_wait == 2'h1) begin
					sample_hold <= 1'b1;
					timer       <= 8'(`AOP_CONV_CYC);
					state       <= AOP_CONV;
				end
			end
			AOP_CONV: begin
				timer <= timer - 8'h1;
				if (timer == 8'h1) begin
					sample_hold  <= 1'b0;
					samples_left <= samples_left - 4'h1;
					timer        <= 8'(`AOP_NORM_GAP_CYC);
					state        <= (samples_left == 4'h1) ?
						AOP_DONE : AOP_GAP;
				end
			end
			AOP_GAP: begin
				// Internally timed extra samples in normal averaging
				timer <= timer - 8'h1;
				if (timer == 8'h1) begin
					sample_hold <= 1'b1;
					timer       <= 8'(`AOP_CONV_CYC);
					state       <= AOP_CONV;
				end
			end
			AOP_DONE: begin
				if (fifo_ready) begin
					if (channel_sequencer_enable)
						mux_select <= !mux_select;
					state <= AOP_IDLE;
				end
			end
			default: state <= AOP_IDLE;
			endcase
		end
	end

	// ****************************************
	// History and averaging
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ref_prev  <= 1'b0;
			need_fill <= 1'b1;
		end else begin
			ref_prev <= reference_source_select;
			if (sw_reset || ref_prev != reference_source_select)
				need_fill <= 1'b1;
			else if (state == AOP_CONV && timer == 8'h1)
				need_fill <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_hist
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					hist_a[gi] <= '0;
					hist_b[gi] <= '0;
				end else if (state == AOP_CONV && timer == 8'h1) begin
					// Shift on every result, so ratio changes need no refill
					if (need_fill || gi == 0) begin
						hist_a[gi] <= conv_a;
						hist_b[gi] <= conv_b;
					end else begin
						// Index clamp keeps entry 0 from naming entry -1
						hist_a[gi] <= hist_a[(gi == 0) ? 0 : gi-1];
						hist_b[gi] <= hist_b[(gi == 0) ? 0 : gi-1];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			norm_sum_a <= '0;
			norm_sum_b <= '0;
		end else if (state == AOP_IDLE) begin
			norm_sum_a <= '0;
			norm_sum_b <= '0;
		end else if (state == AOP_CONV && timer == 8'h1) begin
			norm_sum_a <= norm_sum_a + (NW+4)'(conv_a);
			norm_sum_b <= norm_sum_b + (NW+4)'(conv_b);
		end
	end

	always_comb begin
		sum_a = '0;
		sum_b = '0;
		for (int i = 0; i < DEPTH; i++) begin
			if (i < (1 << shift)) begin
				sum_a = sum_a + (NW+4)'(hist_a[i]);
				sum_b = sum_b + (NW+4)'(hist_b[i]);
			end
		end
		if (!rolling) begin
			sum_a = os_valid ? norm_sum_a : (NW+4)'(hist_a[0]);
			sum_b = os_valid ? norm_sum_b : (NW+4)'(hist_b[0]);
		end
		// Shift keeps two fraction bits for boost
		avg_a = OW'(({sum_a, 2'h0}) >> shift);
		avg_b = OW'(({sum_b, 2'h0}) >> shift);
		if (!boost) begin
			avg_a = OW'(avg_a >> `AOP_BOOST_BITS);
			avg_b = OW'(avg_b >> `AOP_BOOST_BITS);
		end
	end

	assign push = (state == AOP_DONE);

	aop_fifo #(
		.WIDTH (2*OW),
		.DEPTH (`AOP_FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   ({avg_a, avg_b}),
		.out_valid (result_valid),
		.out_ready (result_ready),
		.out_data  (result_data)
	);

	// ****************************************
	// Limits, flag pin and power
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			limit_status      <= 4'h0;
			flag_out          <= 1'b0;
			flag_oe_n         <= 1'b1;
			result_boosted    <= 1'b0;
			analog_power_down <= 1'b0;
		end else begin
			analog_power_down <= power_down_select;
			flag_oe_n <= !(serial_output_lane_select && limit_flag_enable);
			if (push && fifo_ready) begin
				// One shared limit pair, any averaging mode
				limit_status <= {avg_b > OW'({upper_limit, 2'h0} >> 2'(2 - 2*boost)),
					avg_b < OW'({lower_limit, 2'h0} >> 2'(2 - 2*boost)),
					avg_a > OW'({upper_limit, 2'h0} >> 2'(2 - 2*boost)),
					avg_a < OW'({lower_limit, 2'h0} >> 2'(2 - 2*boost))};
				flag_out <= (avg_a > OW'({upper_limit, 2'h0} >> 2'(2 - 2*boost))) ||
					(avg_a < OW'({lower_limit, 2'h0} >> 2'(2 - 2*boost))) ||
					(avg_b > OW'({upper_limit, 2'h0} >> 2'(2 - 2*boost))) ||
					(avg_b < OW'({lower_limit, 2'h0} >> 2'(2 - 2*boost)));
				result_boosted <= boost;
			end else begin
				if (sw_reset)
					limit_status <= 4'h0;
				if (cs_fall)
					flag_out <= 1'b0;
			end
		end
	end

	a_start_on_fall: assert property (@(posedge core_clk) disable iff (!resetn)
		($rose(sample_hold) && $past(state) == AOP_IDLE) |-> $past(cs_fall))
		else $error("conversion began without chip-select fall");
	a_seq_wait_two: assert property (@(posedge core_clk) disable iff (!resetn)
		(state == AOP_IDLE && cs_fall && !power_down_select && !sw_reset &&
		channel_sequencer_enable && os_valid) |=> (state == AOP_WAIT) [*2])
		else $error("sequencer wait not two cycles");
	a_pd_no_conv: assert property (@(posedge core_clk) disable iff (!resetn)
		(state == AOP_IDLE && power_down_select) |=> state != AOP_CONV)
		else $error("conversion while powered down");
	a_flag_clear_cs: assert property (@(posedge core_clk) disable iff (!resetn)
		(cs_fall && !(push && fifo_ready)) |=> !flag_out)
		else $error("flag not cleared on chip-select fall");
	a_status_swreset: assert property (@(posedge core_clk) disable iff (!resetn)
		(sw_reset && !(push && fifo_ready)) |=> limit_status == 4'h0)
		else $error("status not cleared on reset");
	a_fill_after_ref: assert property (@(posedge core_clk) disable iff (!resetn)
		(ref_prev != reference_source_select) |=> need_fill)
		else $error("history fill not armed");
	a_shift_each_conv: assert property (@(posedge core_clk) disable iff (!resetn)
		(state == AOP_CONV && timer == 8'h1) |=> hist_a[0] == $past(conv_a))
		else $error("result not shifted into history");
	a_oe_follows_en: assert property (@(posedge core_clk) disable iff (!resetn)
		(serial_output_lane_select && limit_flag_enable) [*2] |-> !flag_oe_n)
		else $error("flag pin not driven when enabled");

	c_rolling_done: cover property (@(posedge core_clk) disable iff (!resetn)
		push && rolling);
	c_normal_done: cover property (@(posedge core_clk) disable iff (!resetn)
		push && os_valid && !rolling);
	c_flag_set: cover property (@(posedge core_clk) disable iff (!resetn)
		$rose(flag_out));
	c_seq_toggle: cover property (@(posedge core_clk) disable iff (!resetn)
		$rose(mux_select));
endmodule : aop_filter

// *** aop_filter_tb_top.sv ***
// Self-checking bench for the oversampling, limit and power block
`timescale 1ns/1ps
module aop_filter_tb_top;
	import aop_pkg::*;
	// **************
	// Signals
	// **************
	logic        core_clk, resetn, start, busy, cs_n, sclk, fill;
	logic [4:0]  nbits;
	logic [15:0] conv_a, conv_b, upper_limit, lower_limit;
	logic [2:0]  oversample_ratio_field;
	logic        averaging_mode_select, resolution_boost_enable;
	logic        serial_output_lane_select, limit_flag_enable;
	logic        power_down_select, soft_reset, result_ready;
	logic        sample_hold, analog_power_down, result_valid;
	logic        result_boosted, flag_out, flag_oe_n;
	logic        seq_en, ref_sel, mux_select, sclk_edge;
	int          edges = 0;
	logic [35:0] result_data;
	logic [3:0]  limit_status;
	logic [15:0] ha [8];
	logic [15:0] hb [8];
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;

	aop_spi_host host (.start, .nbits, .cs_n, .sclk, .busy);
	// Hard reset held off: soft reset covers the same clearing
	aop_filter dut (.core_clk, .resetn, .cs_n, .sclk, .conv_a, .conv_b,
		.oversample_ratio_field, .averaging_mode_select,
		.resolution_boost_enable, .channel_sequencer_enable(seq_en),
		.reference_source_select(ref_sel), .serial_output_lane_select,
		.limit_flag_enable, .power_down_select, .soft_reset,
		.hard_reset(1'b0), .upper_limit, .lower_limit, .sample_hold,
		.mux_select, .analog_power_down, .result_valid, .result_ready,
		.result_data, .result_boosted, .limit_status, .flag_out,
		.flag_oe_n, .sclk_edge);
	always @(posedge core_clk)
		if (sclk_edge === 1'b1)
			edges++;

	// **************
	// Helpers
	// **************
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic check(input string what, input logic [35:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Normal mode repeats one input, so its mean is the newest entry
	function automatic logic [17:0] mean(input logic [15:0] h [8]);
		logic [20:0] s;
		int k;
		s = '0;
		k = (oversample_ratio_field inside {[1:3]}) ?
			int'(oversample_ratio_field) : 0;
		for (int i = 0; i < (1 << k); i++)
			s += averaging_mode_select ? h[i] : h[0];
		if (k != 0 && resolution_boost_enable)
			s = s << 2;
		return 18'(s >> k);
	endfunction : mean
	task automatic convert(input logic [15:0] a, b, input bit clr);
		int n;
		conv_a = a;
		conv_b = b;
		nbits = (resolution_boost_enable && oversample_ratio_field != 0)
			? 5'd18 : 5'd16;
		edges = 0;
		start = 1'b1;
		@(negedge core_clk) start = 1'b0;
		if (clr) begin
			repeat (5) @(negedge core_clk);
			check("flag clear", flag_out, 1'b0);
		end
		for (n = 0; n < 100 && result_valid !== 1'b1; n++)
			@(negedge core_clk);
		for (int i = 7; i >= 0; i--) begin
			ha[i] = (fill || i == 0) ? a : ha[i-1];
			hb[i] = (fill || i == 0) ? b : hb[i-1];
		end
		fill = 1'b0;
		check("result", result_data, {mean(ha), mean(hb)});
		check("boosted", result_boosted, resolution_boost_enable &&
			oversample_ratio_field != 0);
		result_ready = 1'b1;
		@(negedge core_clk) result_ready = 1'b0;
		@(negedge busy);
		@(negedge core_clk);
		check("sclk edges", edges, nbits);
	endtask : convert

	// **************
	// Scenarios
	// **************
	task automatic t_plain();
		resolution_boost_enable = 1'b1;
		convert(16'h1234, 16'habcd, 0);
		convert(16'h0f0f, 16'h00ff, 0);
	endtask : t_plain
	task automatic t_limit();
		oversample_ratio_field = 3'h1;
		resolution_boost_enable = 1'b0;
		convert(16'h9000, 16'h0800, 0);
		check("status", limit_status, 4'b0110);
		check("flag", {flag_out, flag_oe_n}, 2'b10);
		convert(16'h4000, 16'h4000, 1);
		check("status", limit_status, 4'b0000);
		convert(16'h0fff, 16'h8001, 0);
		check("status", limit_status, 4'b1001);
		serial_output_lane_select = 1'b0;
		repeat (2) @(negedge core_clk);
		check("flag oe", flag_oe_n, 1'b1);
		soft_reset = 1'b1;
		@(negedge core_clk) soft_reset = 1'b0;
		@(negedge core_clk);
		fill = 1'b1;
		check("status", limit_status, 4'b0000);
	endtask : t_limit
	task automatic t_rolling();
		averaging_mode_select = 1'b1;
		for (int r = 3; r >= 1; r--) begin
			for (int bst = 0; bst < 2; bst++) begin
				oversample_ratio_field = 3'(r);
				resolution_boost_enable = bst[0];
				@(negedge core_clk);
				convert(16'(16'h0731 * r + bst * 16'h0101),
					16'(16'hfff0 - 16'h0333 * r), 0);
			end
		end
	endtask : t_rolling
	task automatic t_power();
		power_down_select = 1'b1;
		repeat (2) @(negedge core_clk);
		check("analog off", analog_power_down, 1'b1);
		edges = 0;
		start = 1'b1;
		@(negedge core_clk) start = 1'b0;
		@(negedge busy);
		@(negedge core_clk);
		check("idle", {result_valid, sample_hold}, 2'b00);
		check("pd sclk edges", edges, nbits);
		power_down_select = 1'b0;
		repeat (25) @(negedge core_clk); // settle
		check("analog on", analog_power_down, 1'b0);
		convert(16'h2222, 16'h3333, 0);
	endtask : t_power
	task automatic t_seq();
		oversample_ratio_field = 3'h1;
		averaging_mode_select = 1'b1;
		seq_en = 1'b1;
		ref_sel = ~ref_sel;
		fill = 1'b1;
		@(negedge core_clk);
		convert(16'h5555, 16'h1111, 0);
		check("mux first", mux_select, 1'b1);
		convert(16'h7777, 16'h2222, 0);
		check("mux second", mux_select, 1'b0);
	endtask : t_seq

	initial begin
		resetn = 1'b0;
		start = 1'b0;
		nbits = 5'd16;
		fill = 1'b1;
		conv_a = '0;
		conv_b = '0;
		upper_limit = 16'h8000;
		lower_limit = 16'h1000;
		oversample_ratio_field = 3'h0;
		averaging_mode_select = 1'b0;
		resolution_boost_enable = 1'b0;
		serial_output_lane_select = 1'b1;
		limit_flag_enable = 1'b1;
		power_down_select = 1'b0;
		soft_reset = 1'b0;
		result_ready = 1'b0;
		seq_en = 1'b0;
		ref_sel = 1'b0;
		repeat (16) @(negedge core_clk);
		resetn = 1'b1;
		@(negedge core_clk);
		t_plain();
		t_limit();
		t_rolling();
		t_power();
		t_seq();
		give_verdict();
	end
endmodule : aop_filter_tb_top

// *** aop_pkg.sv ***
// Types for the oversampling, limit and power block
package aop_pkg;
	typedef enum logic [2:0] {
		AOP_IDLE,
		AOP_WAIT,
		AOP_CONV,
		AOP_GAP,
		AOP_DONE
	} aop_state_e;
endpackage : aop_pkg

// *** aop_spi_host.sv ***
// Host model framing conversions with chip select and serial clock
`timescale 1ns/1ps
module aop_spi_host #(
	parameter int HALF_NS = 80
) (
	// Frame request
	input  wire logic       start,
	input  wire logic [4:0] nbits,
	// Pins
	output logic            cs_n,
	output logic            sclk,
	output logic            busy
);
	// *****************
	// Frame generator
	// *****************
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		busy = 1'b0;
	end
	// Clock stands low between frames, as a real host leaves it
	always @(posedge start) begin
		busy = 1'b1;
		cs_n = 1'b0;
		repeat (nbits) begin
			#HALF_NS sclk = 1'b1;
			#HALF_NS sclk = 1'b0;
		end
		#HALF_NS cs_n = 1'b1;
		busy = 1'b0;
	end
endmodule : aop_spi_host
